//--- verilog/tag_cmd_defines.svh
// Constants of the tag command handshake: mode codes, field widths,
// error codes and process-data timing. Definitions only.
`ifndef TAG_CMD_DEFINES_SVH
`define TAG_CMD_DEFINES_SVH

// Mode codes carried in the low nibble of output byte 0
`define MODE_AUTO_READ 4'h1
`define MODE_AUTO_WRITE 4'h2
`define MODE_READ 4'h3
`define MODE_WRITE 4'h4
`define MODE_SCAN_UID 4'h5
`define MODE_RESET `MODE_SCAN_UID

// Field widths
`define DATA_BYTES 28
`define DATA_W 224
`define UID_W 64
`define ADDR_W 8
`define LEN_W 5
`define TS_W 32

// Error codes; zero means success
`define ERR_NONE 8'h00
`define ERR_CMD_UNSUPPORTED 8'h01
`define ERR_FORMAT 8'h02
`define ERR_OPTION 8'h03
`define ERR_CMD_PROBLEM 8'h05
`define ERR_TAG_COMM 8'h06
`define ERR_TAG 8'h0F
`define ERR_NO_BLOCK 8'h10
`define ERR_BLOCK_PROTECTED 8'h12
`define ERR_CRC 8'h15
`define ERR_COLLISION 8'h16
`define ERR_TIMEOUT 8'h17
`define ERR_APP_MEM 8'h18
`define ERR_APP_QUEUE 8'h19
`define ERR_APP_LOGRN 8'h1A
`define ERR_APP_LOGPSW 8'h1B
`define ERR_GENERAL 8'hFF

// Block sizes of transponder user memory, in bytes
`define BLOCK_SMALL 4
`define BLOCK_LARGE 8

// Process-data cycle: time in ns and count of 50 ns clocks (rounded down)
`define CLK_PERIOD_NS 50
`define PD_CYCLE_NS 2000000
`define PD_CYCLE_CLKS (`PD_CYCLE_NS / `CLK_PERIOD_NS)

`endif

//--- verilog/tag_cmd_pkg.sv
// Types shared by both ends of the tag command handshake.
// Assumes the constants header for widths.
`include "tag_cmd_defines.svh"
package tag_cmd_pkg;
    typedef enum logic [0:0] {ST_IDLE, ST_BUSY} dev_state_t;
    typedef logic [`ADDR_W-1:0] addr_t;
    typedef logic [`LEN_W-1:0] len_t;
    typedef logic [7:0] err_t;
endpackage : tag_cmd_pkg

//--- verilog/tag_cmd_if.sv
// Process-data link between the master end and the device end.
// Assumes one common clock; the bench instantiates and joins both ends.
`include "tag_cmd_defines.svh"
interface tag_cmd_if;
    // Output process data, master to device, one strobe per cycle
    logic pd_out_stb;
    logic [3:0] pd_out_mode;
    logic pd_out_start;
    logic [`ADDR_W-1:0] pd_out_addr;
    logic [`LEN_W-1:0] pd_out_len;
    logic [`DATA_W-1:0] pd_out_data;
    // Input process data, device to master
    logic pd_in_stb;
    logic pd_in_ready;
    logic [`UID_W-1:0] pd_in_uid;
    logic [7:0] pd_in_err;
    logic pd_in_ant;
    logic [1:0] pd_in_alarm;
    logic [7:0] pd_in_rssi;
    logic [`TS_W-1:0] pd_in_t_entry;
    logic [`TS_W-1:0] pd_in_t_exit;
    logic [`DATA_W-1:0] pd_in_data;

    modport master (
        output pd_out_stb, pd_out_mode, pd_out_start, pd_out_addr, pd_out_len, pd_out_data,
        input pd_in_stb, pd_in_ready, pd_in_uid, pd_in_err, pd_in_ant, pd_in_alarm,
        input pd_in_rssi, pd_in_t_entry, pd_in_t_exit, pd_in_data
    );
    modport device (
        input pd_out_stb, pd_out_mode, pd_out_start, pd_out_addr, pd_out_len, pd_out_data,
        output pd_in_stb, pd_in_ready, pd_in_uid, pd_in_err, pd_in_ant, pd_in_alarm,
        output pd_in_rssi, pd_in_t_entry, pd_in_t_exit, pd_in_data
    );
endinterface : tag_cmd_if

//--- verilog/tag_device_end.sv
// Device end of the tag command handshake: decodes mode and start bit,
// drives the tag engine, answers every output cycle with input data.
// Assumes the tag engine on the user side shares clk.
//
// Operation
// - Mode codes 1..5 select the five modes
// - Master puts mode in byte 0 low nibble
// - Successful command inverts the done flag (code: auto modes only; single modes copy the start bit)
// - Mode change launched with start bit one
// - Scan mode reports a UID each cycle
// - No tag: keep reporting last UID
// - Scan starts at once, flag toggles each cycle
// - Report antenna, error, alarms, RSSI, timestamps
// - Scan UID mode after reset
// - Master supplies start address and length
// - Single read/write runs once per command
// - Single command waits for next transponder
// - Each start toggle is one new request
// - Single success copies start into done flag
// - Auto modes repeat without start toggles
// - Auto modes invert flag per transfer (code: per successful transfer only)
// - Data field is 28 bytes
// - Master requests whole 4/8-byte blocks
// - Numeric error codes reported in input data
//
// The implementer's own choices: the strobed register port and the register addresses.
`include "tag_cmd_defines.svh"
module tag_device_end (
    input wire logic clk,
    input wire logic rst_n,
    tag_cmd_if.device pd,
    // Tag engine side
    input wire logic tag_present,
    input wire logic [`UID_W-1:0] tag_uid,
    input wire logic tag_ant_ok,
    input wire logic [1:0] tag_alarm,
    input wire logic [7:0] tag_rssi,
    input wire logic [`TS_W-1:0] tag_t_entry,
    input wire logic [`TS_W-1:0] tag_t_exit,
    input wire logic op_done,
    input wire logic [7:0] op_err,
    input wire logic [`DATA_W-1:0] op_rdata,
    output logic op_go,
    output logic op_write,
    output logic [`ADDR_W-1:0] op_addr,
    output logic [`LEN_W-1:0] op_len,
    output logic [`DATA_W-1:0] op_wdata
);
    logic [3:0] mode_ff;
    logic start_prev_ff;
    logic pend_ff;
    logic pend_tog_ff;
    logic busy_auto_ff;
    logic busy_tog_ff;
    tag_cmd_pkg::dev_state_t state_ff;
    logic ready_ff;
    logic [`UID_W-1:0] uid_ff;
    logic [7:0] err_ff;
    logic [`DATA_W-1:0] rdata_ff;
    logic in_stb_ff;
    logic go_ff;
    logic write_ff;
    logic [`ADDR_W-1:0] addr_ff;
    logic [`LEN_W-1:0] len_ff;
    logic [`DATA_W-1:0] wdata_ff;
    logic ant_ff;
    logic [1:0] alarm_ff;
    logic [7:0] rssi_ff;
    logic [`TS_W-1:0] t_entry_ff;
    logic [`TS_W-1:0] t_exit_ff;

    logic nxt_mode_chg;
    logic nxt_start_tog;
    logic is_single;
    logic is_auto;
    logic single_req;
    logic launch;
    logic done_ok;

    // Decode of the incoming output cycle
    assign nxt_mode_chg = pd.pd_out_stb && (pd.pd_out_mode != mode_ff);
    assign nxt_start_tog = pd.pd_out_stb && (pd.pd_out_start != start_prev_ff);
    assign is_single = (mode_ff == `MODE_READ) || (mode_ff == `MODE_WRITE);
    assign is_auto = (mode_ff == `MODE_AUTO_READ) || (mode_ff == `MODE_AUTO_WRITE);
    // A new single mode only launches with start high (auto launches without it); in a single mode a toggle is a request
    assign single_req = (nxt_mode_chg && pd.pd_out_start)
        || (!nxt_mode_chg && nxt_start_tog && is_single);
    // Launch only with a transponder in the field, else the request waits
    assign launch = (state_ff == tag_cmd_pkg::ST_IDLE) && tag_present && !nxt_mode_chg
        && ((is_single && pend_ff) || is_auto);
    assign done_ok = (state_ff == tag_cmd_pkg::ST_BUSY) && op_done && (op_err == `ERR_NONE);

    // Mode register, scan mode out of reset; low nibble of byte 0 only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_ff <= `MODE_RESET;
        end else if (pd.pd_out_stb) begin
            mode_ff <= pd.pd_out_mode;
        end
    end

    // Previous start bit, for toggle detection
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            start_prev_ff <= 1'b0;
        end else if (pd.pd_out_stb) begin
            start_prev_ff <= pd.pd_out_start;
        end
    end

    // Pending single request; a fresh request wins over the clear on launch
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_ff <= 1'b0;
            pend_tog_ff <= 1'b0;
        end else if (single_req) begin
            pend_ff <= 1'b1;
            pend_tog_ff <= pd.pd_out_start;
        end else if (nxt_mode_chg || launch) begin
            pend_ff <= 1'b0;
        end
    end

    // Engine sequencing: one transfer in flight at a time
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= tag_cmd_pkg::ST_IDLE;
            busy_auto_ff <= 1'b0;
            busy_tog_ff <= 1'b0;
        end else begin
            unique case (state_ff)
                tag_cmd_pkg::ST_IDLE: begin
                    if (launch) begin
                        state_ff <= tag_cmd_pkg::ST_BUSY;
                        busy_auto_ff <= is_auto;
                        busy_tog_ff <= pend_tog_ff;
                    end
                end
                tag_cmd_pkg::ST_BUSY: begin
                    if (op_done) begin
                        state_ff <= tag_cmd_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Transfer request to the engine, a one-cycle go pulse
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            go_ff <= 1'b0;
            write_ff <= 1'b0;
            addr_ff <= '0;
            len_ff <= '0;
            wdata_ff <= '0;
        end else begin
            go_ff <= launch;
            if (launch) begin
                write_ff <= (mode_ff == `MODE_WRITE) || (mode_ff == `MODE_AUTO_WRITE);
                addr_ff <= pd.pd_out_addr;
                len_ff <= pd.pd_out_len;
                wdata_ff <= pd.pd_out_data;
            end
        end
    end

    // Done flag: scan toggles per cycle, single copies start, auto inverts.
    // Failure or waiting leaves it alone so the master sees no completion.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ready_ff <= 1'b0;
        end else if (pd.pd_out_stb && pd.pd_out_mode == `MODE_SCAN_UID) begin
            ready_ff <= ~ready_ff;
        end else if (done_ok && busy_auto_ff) begin
            ready_ff <= ~ready_ff;
        end else if (done_ok) begin
            ready_ff <= busy_tog_ff;
        end
    end

    // Last seen UID survives the tag leaving the field
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            uid_ff <= '0;
        end else if (tag_present) begin
            uid_ff <= tag_uid;
        end
    end

    // Error code of the last finished transfer, read data of the last successful one
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            err_ff <= `ERR_NONE;
            rdata_ff <= '0;
        end else if ((state_ff == tag_cmd_pkg::ST_BUSY) && op_done) begin
            err_ff <= op_err;
            if (op_err == `ERR_NONE) begin
                rdata_ff <= op_rdata;
            end
        end
    end

    // Status sampled every clock and passed on one clock later, not held between answers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ant_ff <= 1'b0;
            alarm_ff <= 2'h0;
            rssi_ff <= 8'h00;
            t_entry_ff <= '0;
            t_exit_ff <= '0;
        end else begin
            ant_ff <= tag_ant_ok;
            alarm_ff <= tag_alarm;
            rssi_ff <= tag_rssi;
            t_entry_ff <= tag_t_entry;
            t_exit_ff <= tag_t_exit;
        end
    end

    // One answer per output cycle, one clock after it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            in_stb_ff <= 1'b0;
        end else begin
            in_stb_ff <= pd.pd_out_stb;
        end
    end

    assign pd.pd_in_stb = in_stb_ff;
    assign pd.pd_in_ready = ready_ff;
    assign pd.pd_in_uid = uid_ff;
    assign pd.pd_in_err = err_ff;
    assign pd.pd_in_ant = ant_ff;
    assign pd.pd_in_alarm = alarm_ff;
    assign pd.pd_in_rssi = rssi_ff;
    assign pd.pd_in_t_entry = t_entry_ff;
    assign pd.pd_in_t_exit = t_exit_ff;
    assign pd.pd_in_data = rdata_ff;
    assign op_go = go_ff;
    assign op_write = write_ff;
    assign op_addr = addr_ff;
    assign op_len = len_ff;
    assign op_wdata = wdata_ff;
endmodule : tag_device_end

//--- verilog/tag_master_end.sv
// Master end: sends output process data once per cycle, forces the start bit high on a mode change,
// toggles it per repeated single request and reports completion from the done flag.
// Assumes the user side shares clk; block size set by parameter.
`include "tag_cmd_defines.svh"
module tag_master_end #(
    parameter int PD_CYCLE_CLKS = `PD_CYCLE_CLKS,
    parameter int BLOCK_BYTES = `BLOCK_SMALL
) (
    input wire logic clk,
    input wire logic rst_n,
    tag_cmd_if.master pd,
    input wire logic cmd_issue,
    input wire logic [3:0] cmd_mode,
    input wire logic [`ADDR_W-1:0] cmd_addr,
    input wire logic [`LEN_W-1:0] cmd_len,
    input wire logic [`DATA_W-1:0] cmd_wdata,
    output logic done,
    output logic [7:0] err,
    output logic [`UID_W-1:0] uid,
    output logic [`DATA_W-1:0] rdata
);
    localparam int CW = $clog2(PD_CYCLE_CLKS + 1);
    localparam logic [`LEN_W-1:0] BMASK = `LEN_W'(BLOCK_BYTES - 1);

    logic [CW-1:0] tick_ff;
    logic stb_ff;
    logic [3:0] mode_ff;
    logic start_ff;
    logic [`ADDR_W-1:0] addr_ff;
    logic [`LEN_W-1:0] len_ff;
    logic [`DATA_W-1:0] wdata_ff;
    logic ready_prev_ff;
    logic done_ff;
    logic [7:0] err_ff;
    logic [`UID_W-1:0] uid_ff;
    logic [`DATA_W-1:0] rdata_ff;
    logic nxt_single;

    assign nxt_single = (cmd_mode == `MODE_READ) || (cmd_mode == `MODE_WRITE);

    // Cycle timer; one output strobe per process-data cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_ff <= '0;
            stb_ff <= 1'b0;
        end else begin
            stb_ff <= (tick_ff == CW'(PD_CYCLE_CLKS - 1));
            if (tick_ff == CW'(PD_CYCLE_CLKS - 1)) begin
                tick_ff <= '0;
            end else begin
                tick_ff <= tick_ff + 1'b1;
            end
        end
    end

    // Command fields; a mode change forces start high, a single repeat toggles it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_ff <= `MODE_RESET;
            start_ff <= 1'b0;
            addr_ff <= '0;
            len_ff <= '0;
            wdata_ff <= '0;
        end else if (cmd_issue) begin
            mode_ff <= cmd_mode;
            addr_ff <= cmd_addr;
            // Round up to whole blocks; overflow past the field wraps
            len_ff <= (cmd_len + BMASK) & ~BMASK;
            wdata_ff <= cmd_wdata;
            if (cmd_mode != mode_ff) begin
                start_ff <= 1'b1;
            end else if (nxt_single) begin
                start_ff <= ~start_ff;
            end
        end
    end

    // Done pulse on each flag change; status captured with each answer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ready_prev_ff <= 1'b0;
            done_ff <= 1'b0;
            err_ff <= `ERR_NONE;
            uid_ff <= '0;
            rdata_ff <= '0;
        end else begin
            done_ff <= pd.pd_in_stb && (pd.pd_in_ready != ready_prev_ff);
            if (pd.pd_in_stb) begin
                ready_prev_ff <= pd.pd_in_ready;
                err_ff <= pd.pd_in_err;
                uid_ff <= pd.pd_in_uid;
                rdata_ff <= pd.pd_in_data;
            end
        end
    end

    assign pd.pd_out_stb = stb_ff;
    assign pd.pd_out_mode = mode_ff;
    assign pd.pd_out_start = start_ff;
    assign pd.pd_out_addr = addr_ff;
    assign pd.pd_out_len = len_ff;
    assign pd.pd_out_data = wdata_ff;
    assign done = done_ff;
    assign err = err_ff;
    assign uid = uid_ff;
    assign rdata = rdata_ff;
endmodule : tag_master_end

//--- bench/tag_cmd_asserts.sv
// Checker of the process-data link joining the master and device ends.
// Assumes one clock, active-low reset and an output strobe every 8 clocks.
`include "tag_cmd_defines.svh"
module tag_cmd_asserts (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pd_out_stb,
    input wire logic [3:0] pd_out_mode,
    input wire logic pd_out_start,
    input wire logic pd_in_stb,
    input wire logic pd_in_ready,
    input wire logic [7:0] pd_in_err,
    input wire logic [`DATA_W-1:0] pd_in_data
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // One output cycle and the answer to it
    sequence s_answer;
        pd_out_stb ##1 pd_in_stb;
    endsequence
    // Seven quiet clocks between output cycles
    sequence s_quiet;
        !pd_out_stb [*7];
    endsequence
    a_answer_next: assert property (pd_out_stb |-> s_answer)
        else $error("no input strobe after output strobe");
    a_answer_cause: assert property (pd_in_stb |-> $past(pd_out_stb))
        else $error("input strobe without output strobe");
    a_cycle_spacing: assert property (pd_out_stb |=> s_quiet ##1 pd_out_stb)
        else $error("output strobe spacing wrong");
    a_scan_toggle: assert property (
        pd_out_stb && pd_out_mode == `MODE_SCAN_UID |=> $changed(pd_in_ready))
        else $error("scan cycle did not toggle ready");
    a_reset_mode: assert property ($rose(rst_n) |-> pd_out_mode == `MODE_RESET)
        else $error("mode after reset is not scan");
    // Scan toggles land beside the input strobe, so those cycles are left out
    a_single_copy: assert property (
        (pd_out_mode inside {`MODE_READ, `MODE_WRITE}) && $changed(pd_in_ready) && !pd_in_stb
        |-> pd_in_ready == pd_out_start)
        else $error("single completion ready differs from start");
    a_fail_keeps: assert property (
        $changed(pd_in_err) && pd_in_err != `ERR_NONE |-> $stable(pd_in_ready))
        else $error("failed transfer moved ready");
    a_data_success: assert property ($changed(pd_in_data) |-> $changed(pd_in_ready))
        else $error("read data changed without ready toggle");
endmodule : tag_cmd_asserts

//--- bench/tag_command_handshake_tb.sv
// Bench joining master and device ends over the link, with a tag engine
// stand-in. Assumes the design files and the constants header.
`include "tag_cmd_defines.svh"
module tag_command_handshake_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic cmd_issue = 1'h0;
    logic [3:0] cmd_mode = 4'h5;
    logic [`ADDR_W-1:0] cmd_addr = '0;
    logic [`LEN_W-1:0] cmd_len = '0;
    logic [`DATA_W-1:0] cmd_wdata = '0;
    logic done, op_go, op_write, tag_ant_ok = 1'h0, op_done = 1'h0, chk_rd = 1'h0;
    logic [7:0] err, tag_rssi = '0, op_err = '0, eng_err = '0;
    logic [`UID_W-1:0] uid, old_uid, tag_uid = '0;
    logic [`DATA_W-1:0] rdata, op_wdata, nxt_rd, op_rdata = '0;
    logic tag_present = 1'h0;
    logic [1:0] tag_alarm = '0;
    logic [`TS_W-1:0] tag_t_entry = '0, tag_t_exit = '0;
    logic [`ADDR_W-1:0] op_addr;
    logic [`LEN_W-1:0] op_len;
    // Odd count: the request after the last failure then carries a start unlike ready
    logic [7:0] codes [17] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h06, 8'h0F, 8'h10, 8'h12,
        8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1A, 8'h1B, 8'hFF, 8'h01};
    // Second read drops start to zero, so the write's forced start of one shows
    logic [3:0] sing_m [3] = '{`MODE_READ, `MODE_READ, `MODE_WRITE};
    logic [3:0] auto_m [2] = '{`MODE_AUTO_READ, `MODE_AUTO_WRITE};
    logic [4:0] sing_l [3] = '{5'h06, 5'h0C, 5'h1D};
    int bad_count = 0, cmp_count = 0, cycles = 0;
    int n_go = 0, n_ok = 0, n_done = 0, lat = 3, busy_cnt = 0, d0, k0;
    logic [`DATA_W-1:0] rd_q [$];

    tag_cmd_if pd ();
    tag_master_end #(.PD_CYCLE_CLKS(8), .BLOCK_BYTES(`BLOCK_SMALL)) tag_master_end_i (
        .clk(clk), .rst_n(rst_n), .pd(pd), .cmd_issue(cmd_issue), .cmd_mode(cmd_mode),
        .cmd_addr(cmd_addr), .cmd_len(cmd_len), .cmd_wdata(cmd_wdata), .done(done),
        .err(err), .uid(uid), .rdata(rdata));
    tag_device_end tag_device_end_i (
        .clk(clk), .rst_n(rst_n), .pd(pd), .tag_present(tag_present), .tag_uid(tag_uid),
        .tag_ant_ok(tag_ant_ok), .tag_alarm(tag_alarm), .tag_rssi(tag_rssi),
        .tag_t_entry(tag_t_entry), .tag_t_exit(tag_t_exit), .op_done(op_done),
        .op_err(op_err), .op_rdata(op_rdata), .op_go(op_go), .op_write(op_write),
        .op_addr(op_addr), .op_len(op_len), .op_wdata(op_wdata));
    tag_cmd_asserts tag_cmd_asserts_i (
        .clk(clk), .rst_n(rst_n), .pd_out_stb(pd.pd_out_stb), .pd_out_mode(pd.pd_out_mode),
        .pd_out_start(pd.pd_out_start), .pd_in_stb(pd.pd_in_stb),
        .pd_in_ready(pd.pd_in_ready), .pd_in_err(pd.pd_in_err), .pd_in_data(pd.pd_in_data));

    always #25 clk = ~clk;

    task automatic check(input string what, input logic [`DATA_W-1:0] seen,
                         input logic [`DATA_W-1:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run

    // Length rounded up to whole blocks; the field wraps past 31
    function automatic logic [`LEN_W-1:0] exp_len();
        return `LEN_W'((int'(cmd_len) + `BLOCK_SMALL - 1) / `BLOCK_SMALL * `BLOCK_SMALL);
    endfunction : exp_len

    task automatic issue(input logic [3:0] m, input logic [`LEN_W-1:0] len);
        @(posedge clk);
        cmd_mode <= m;
        cmd_addr <= `ADDR_W'($urandom);
        cmd_len <= len;
        cmd_wdata <= {7{$urandom}};
        cmd_issue <= 1'h1;
        @(posedge clk);
        cmd_issue <= 1'h0;
    endtask : issue

    // Bounded wait so a lost completion cannot hang the run
    task automatic wait_done(input int lim);
        repeat (lim) begin
            @(posedge clk);
            #1;
            if (done === 1'h1) break;
        end
        check("done", done, 1'h1);
    endtask : wait_done

    // Hang guard: about five times the expected run length
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            bad_count++;
            complete_run();
        end
    end

    // Tag engine stand-in: one transfer at a time, answers lat clocks after launch
    always @(posedge clk) begin
        op_done <= 1'h0;
        if (op_go === 1'h1) begin
            n_go++;
            check("overlap", busy_cnt != 0, 1'h0);
            check("op_write", op_write, cmd_mode inside {`MODE_WRITE, `MODE_AUTO_WRITE});
            check("op_addr", op_addr, cmd_addr);
            check("op_len", op_len, exp_len());
            if (op_write === 1'h1) check("op_wdata", op_wdata, cmd_wdata);
            busy_cnt <= lat;
        end else if (busy_cnt == 1) begin
            nxt_rd = {7{$urandom}};
            op_done <= 1'h1;
            op_err <= eng_err;
            op_rdata <= nxt_rd;
            if (eng_err == 8'h00) begin
                n_ok++;
                if (chk_rd) rd_q.push_back(nxt_rd);
            end
            busy_cnt <= 0;
        end else if (busy_cnt > 1) begin
            busy_cnt <= busy_cnt - 1;
        end
    end

    // Completions seen by the master, read data against the model queue
    always @(posedge clk) begin
        if (done === 1'h1) begin
            n_done++;
            if (chk_rd) check("rdata", rdata, rd_q.pop_front());
        end
    end

    initial begin
        void'($urandom(32'h7400));
        repeat (8) @(posedge clk);
        rst_n <= 1'h1;
        tag_present <= 1'h1;
        tag_uid <= {2{$urandom}};
        tag_ant_ok <= 1'h1;
        tag_alarm <= 2'h2;
        tag_rssi <= 8'($urandom);
        tag_t_entry <= $urandom;
        tag_t_exit <= $urandom;
        // Scan is the reset mode: one toggle per output cycle
        wait_done(40);
        n_done = 0;
        repeat (32) @(posedge clk);
        #1;
        check("scan toggles", n_done, 4);
        check("uid", uid, tag_uid);
        check("status", {pd.pd_in_ant, pd.pd_in_alarm, pd.pd_in_rssi, pd.pd_in_t_entry,
            pd.pd_in_t_exit}, {tag_ant_ok, tag_alarm, tag_rssi, tag_t_entry, tag_t_exit});
        @(posedge clk);
        old_uid = tag_uid;
        tag_present <= 1'h0;
        tag_uid <= ~old_uid;
        repeat (24) @(posedge clk);
        #1;
        check("uid kept", uid, old_uid);
        // Single read, read again by toggle, then write with a wrapping length
        chk_rd = 1'h1;
        @(posedge clk);
        tag_present <= 1'h1;
        foreach (sing_m[i]) begin
            n_go = 0;
            issue(sing_m[i], sing_l[i]);
            wait_done(40);
            check("err", err, 8'h00);
            check("ready", pd.pd_in_ready, pd.pd_out_start);
            repeat (24) @(posedge clk);
            #1;
            check("one launch", n_go, 1);
        end
        // Every error code: shown, flag held, request dropped
        foreach (codes[i]) begin
            eng_err = codes[i];
            d0 = n_done;
            issue(`MODE_READ, 5'h04);
            repeat (24) @(posedge clk);
            #1;
            check("err code", pd.pd_in_err, codes[i]);
            check("no done", n_done, d0);
        end
        // No tag: the request waits for the next arrival
        eng_err = 8'h00;
        @(posedge clk);
        tag_present <= 1'h0;
        n_go = 0;
        issue(`MODE_READ, 5'h08);
        repeat (24) @(posedge clk);
        #1;
        check("held", n_go, 0);
        @(posedge clk);
        tag_present <= 1'h1;
        repeat (3) @(posedge clk);
        #1;
        check("pending", n_go, 1);
        wait_done(40);
        // Auto modes: slow engine so every toggle lands in its own cycle
        chk_rd = 1'h0;
        lat = 12;
        foreach (auto_m[i]) begin
            @(posedge clk);
            tag_present <= 1'h0;
            issue(auto_m[i], 5'h08);
            repeat (16) @(posedge clk);
            #1;
            d0 = n_done;
            k0 = n_ok;
            @(posedge clk);
            tag_present <= 1'h1;
            repeat (80) @(posedge clk);
            tag_present <= 1'h0;
            repeat (40) @(posedge clk);
            #1;
            check("auto runs", n_ok - k0 >= 4, 1'h1);
            check("auto toggles", n_done - d0, n_ok - k0);
        end
        complete_run();
    end
endmodule : tag_command_handshake_tb
